/* File: hw/dsb_pkg.sv */
package dsb_pkg;

  // memory organisation, selected by software
  typedef enum logic [1:0] {
    DSB_ORG_X8  = 2'b00,
    DSB_ORG_X9  = 2'b01,
    DSB_ORG_X18 = 2'b10,
    DSB_ORG_X36 = 2'b11
  } dsb_org_t;

  localparam int          DSB_DATA_W   = 36;
  localparam int          DSB_ADDR_W   = 4;
  localparam int          DSB_WORDS    = 16;
  localparam int          DSB_BUF_DEPTH = 2;
  localparam int          DSB_AXI_AW   = 8;
  localparam int          DSB_CNT_W    = 16;

  // register byte offsets
  localparam logic [7:0]  DSB_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  DSB_OFF_STATUS  = 8'h04;
  localparam logic [7:0]  DSB_OFF_WRBEATS = 8'h08;
  localparam logic [7:0]  DSB_OFF_REFUSED = 8'h0c;

  // field positions
  localparam int          DSB_CTRL_ORG_LSB    = 0;
  localparam int          DSB_STAT_SCLK_BIT   = 0;
  localparam int          DSB_STAT_BUSY_BIT   = 1;
  localparam int          DSB_STAT_RDPEND_BIT = 2;
  localparam int          DSB_STAT_ROOM_BIT   = 3;

  // reset values
  localparam dsb_org_t    DSB_ORG_RST  = DSB_ORG_X36;

  // lane widths and bus answers
  localparam int          DSB_NIB_W    = 4;
  localparam int          DSB_LANE_W   = 9;
  localparam logic [1:0]  DSB_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  DSB_RESP_SLVERR = 2'b10;

endpackage : dsb_pkg

/* File: hw/dsb_buf.sv */
`timescale 1ns/1ps
// shift-register fifo: entry 0 is always the head, so the output is a flop
module dsb_buf #(
  parameter int W     = 36,
  parameter int DEPTH = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_r [DEPTH];
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic [CW-1:0] slot;
  logic          push;
  logic          pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem_r[0];
  assign slot     = count_r - CW'(pop);

  always_comb begin
    count_nxt = count_r + CW'(push) - CW'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r   <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      in_ready  <= count_nxt < CW'(DEPTH);
      out_valid <= count_nxt != '0;
    end
  end

  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mem_r[g] <= '0;
      end else if (push && slot == CW'(g)) begin
        mem_r[g] <= in_data;
      end else if (pop) begin
        if (g < DEPTH - 1) begin
          mem_r[g] <= mem_r[(g + 1) % DEPTH];
        end
      end
    end
  end

endmodule : dsb_buf

/* File: hw/dsb_core.sv */
`timescale 1ns/1ps
// What this block does
// - x18/x36: first beat at given address, second beat with address bit 0 inverted.
// - x8/x9: burst bit forced to zero for first word, one for second.
// - x8: nibble select 0 low writes [3:0], select 1 low writes [7:4].
// - x18: select 0 low writes [8:0], select 1 low writes [17:9].
// - x9: one select gates the whole nine-bit word of each beat.
// - x36: four selects each gate one nine-bit lane of the word.
// - all selects high on a beat: that word stays unchanged.
// - selects sampled per beat, so the two beats may use different masks.
// - after power-up deselected, outputs not driven until a read is loaded.
// - write data taken on both beat edges; read data driven per beat.
// - write beats at t+1 both halves; read beats at t+1 second half, t+2 first.
module dsb_core
  import dsb_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite slave
  input  wire logic [DSB_AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [DSB_AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // memory side
  input  wire logic                    single_clock_strap,
  input  wire logic                    load_cmd_n,
  input  wire logic                    read_not_write,
  input  wire logic [DSB_ADDR_W-1:0]   mem_addr,
  input  wire logic [DSB_DATA_W-1:0]   wr_data,
  input  wire logic [3:0]              lane_write_select_n,
  input  wire logic [1:0]              nibble_write_select_n,
  output logic                         k_rise_phase,
  output logic                         read_room,
  output logic [DSB_DATA_W-1:0]        rd_data,
  output logic                         rd_valid,
  output logic                         rd_drive_en,
  input  wire logic                    rd_ready
);

  logic [DSB_DATA_W-1:0]  mem_r [DSB_WORDS];
  dsb_org_t               org_r;
  logic                   strap_taken_r;
  logic                   single_clk_r;

  // command slots: a = loaded, waiting for its data cycle; b = in its data cycle
  logic                   cmd_a_v_r;
  logic                   cmd_a_rd_r;
  logic [DSB_ADDR_W-1:0]  cmd_a1_r;
  logic [DSB_ADDR_W-1:0]  cmd_a2_r;
  logic                   cmd_b_v_r;
  logic                   cmd_b_rd_r;
  logic [DSB_ADDR_W-1:0]  cmd_b2_r;
  logic [DSB_ADDR_W-1:0]  cmd_b1_r;
  logic                   rd2_v_r;
  logic [DSB_ADDR_W-1:0]  rd2_addr_r;
  // registered write beat, committed to the array one cycle later
  logic                   wb_v_r;
  logic [DSB_ADDR_W-1:0]  wb_addr_r;
  logic [DSB_DATA_W-1:0]  wb_data_r;
  logic [DSB_DATA_W-1:0]  wb_mask_r;
  logic [DSB_CNT_W-1:0]   wr_beats_r;
  logic [DSB_CNT_W-1:0]   refused_r;
  logic                   load_hit;
  logic                   room;
  logic                   accept;
  logic                   beat_wr;
  logic [DSB_ADDR_W-1:0]  beat_addr;
  logic                   push_v;
  logic [DSB_ADDR_W-1:0]  push_addr;
  logic [DSB_DATA_W-1:0]  push_data;
  logic                   buf_in_ready;
  logic                   buf_out_valid;
  logic [DSB_AXI_AW-1:0]  aw_addr_r;
  logic                   aw_got_r;
  logic [31:0]            w_data_r;
  logic [3:0]             w_strb_r;
  logic                   w_got_r;
  logic                   do_write;

  function automatic logic [DSB_DATA_W-1:0] width_mask(dsb_org_t org);
    logic [DSB_DATA_W-1:0] m;
    m = '0;
    unique case (org)
      DSB_ORG_X8:  m[2*DSB_NIB_W-1:0]  = '1;
      DSB_ORG_X9:  m[DSB_LANE_W-1:0]   = '1;
      DSB_ORG_X18: m[2*DSB_LANE_W-1:0] = '1;
      DSB_ORG_X36: m                   = '1;
    endcase
    return m;
  endfunction : width_mask

  // active-low selects turned into a per-bit write mask
  function automatic logic [DSB_DATA_W-1:0] lane_mask(dsb_org_t org, logic [3:0] lws_n, logic [1:0] nws_n);
    logic [DSB_DATA_W-1:0] m;
    m = '0;
    unique case (org)
      DSB_ORG_X8: begin
        m[DSB_NIB_W-1:0]           = {DSB_NIB_W{~nws_n[0]}};
        m[2*DSB_NIB_W-1:DSB_NIB_W] = {DSB_NIB_W{~nws_n[1]}};
      end
      DSB_ORG_X9:  m[DSB_LANE_W-1:0] = {DSB_LANE_W{~lws_n[0]}};
      DSB_ORG_X18: begin
        for (int i = 0; i < 2; i++) begin
          m[i*DSB_LANE_W +: DSB_LANE_W] = {DSB_LANE_W{~lws_n[i]}};
        end
      end
      DSB_ORG_X36: begin
        for (int i = 0; i < 4; i++) begin
          m[i*DSB_LANE_W +: DSB_LANE_W] = {DSB_LANE_W{~lws_n[i]}};
        end
      end
    endcase
    return m;
  endfunction : lane_mask

  function automatic logic [DSB_ADDR_W-1:0] first_addr(dsb_org_t org, logic [DSB_ADDR_W-1:0] a);
    if (org == DSB_ORG_X8 || org == DSB_ORG_X9) return {a[DSB_ADDR_W-1:1], 1'b0};
    return a;
  endfunction : first_addr

  function automatic logic [DSB_ADDR_W-1:0] second_addr(dsb_org_t org, logic [DSB_ADDR_W-1:0] a);
    if (org == DSB_ORG_X8 || org == DSB_ORG_X9) return {a[DSB_ADDR_W-1:1], 1'b1};
    return {a[DSB_ADDR_W-1:1], ~a[0]};
  endfunction : second_addr

  // positive input clock rises every other cycle; loads only count there
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      k_rise_phase <= 1'b1;
    end else begin
      k_rise_phase <= ~k_rise_phase;
    end
  end

  // strap caught once, at the first edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_taken_r <= 1'b0;
      single_clk_r  <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      single_clk_r  <= single_clock_strap;
    end
  end

  // a read needs two free buffer slots; the buffer holds exactly one burst,
  // so reads cannot be issued back to back - traded for a small buffer
  assign room     = ~buf_out_valid & ~(cmd_a_v_r & cmd_a_rd_r) & ~(cmd_b_v_r & cmd_b_rd_r) & ~rd2_v_r;
  assign load_hit = k_rise_phase & ~load_cmd_n;
  assign accept   = load_hit & (~read_not_write | room);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_room <= 1'b0;
    end else begin
      read_room <= room;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_a_v_r  <= 1'b0;
      cmd_a_rd_r <= 1'b0;
      cmd_a1_r   <= '0;
      cmd_a2_r   <= '0;
      cmd_b_v_r  <= 1'b0;
      cmd_b_rd_r <= 1'b0;
      cmd_b1_r   <= '0;
      cmd_b2_r   <= '0;
    end else if (k_rise_phase) begin
      cmd_a_v_r  <= accept;
      cmd_a_rd_r <= read_not_write;
      cmd_a1_r   <= first_addr(org_r, mem_addr);
      cmd_a2_r   <= second_addr(org_r, mem_addr);
      cmd_b_v_r  <= cmd_a_v_r;
      cmd_b_rd_r <= cmd_a_rd_r;
      cmd_b1_r   <= cmd_a1_r;
      cmd_b2_r   <= cmd_a2_r;
    end
  end

  // first beat on the K rise of t+1, second on the following half cycle
  always_comb begin
    beat_wr   = 1'b0;
    beat_addr = cmd_a1_r;
    if (k_rise_phase && cmd_a_v_r && !cmd_a_rd_r) begin
      beat_wr   = 1'b1;
    end else if (!k_rise_phase && cmd_b_v_r && !cmd_b_rd_r) begin
      beat_wr   = 1'b1;
      beat_addr = cmd_b2_r;
    end
  end

  // selects registered on the same edge as their data word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb_v_r    <= 1'b0;
      wb_addr_r <= '0;
      wb_data_r <= '0;
      wb_mask_r <= '0;
    end else begin
      wb_v_r    <= beat_wr;
      wb_addr_r <= beat_addr;
      wb_data_r <= wr_data & width_mask(org_r);
      wb_mask_r <= lane_mask(org_r, lane_write_select_n, nibble_write_select_n);
    end
  end

  // unselected lanes keep their stored bits; an empty mask stores nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DSB_WORDS; i++) begin
        mem_r[i] <= '0;
      end
    end else if (wb_v_r) begin
      mem_r[wb_addr_r] <= (mem_r[wb_addr_r] & ~wb_mask_r) | (wb_data_r & wb_mask_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_beats_r <= '0;
      refused_r  <= '0;
    end else begin
      if (wb_v_r && wb_mask_r != '0) wr_beats_r <= wr_beats_r + DSB_CNT_W'(1);
      if (load_hit && !accept) refused_r <= refused_r + DSB_CNT_W'(1);
    end
  end

  // read beats: second half of t+1, then first half of t+2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd2_v_r    <= 1'b0;
      rd2_addr_r <= '0;
    end else begin
      rd2_v_r    <= !k_rise_phase && cmd_b_v_r && cmd_b_rd_r;
      rd2_addr_r <= cmd_b2_r;
    end
  end

  always_comb begin
    push_v    = 1'b0;
    push_addr = cmd_b1_r;
    if (!k_rise_phase && cmd_b_v_r && cmd_b_rd_r) begin
      push_v    = 1'b1;
    end else if (k_rise_phase && rd2_v_r) begin
      push_v    = 1'b1;
      push_addr = rd2_addr_r;
    end
  end

  // a write beat to the same word two cycles ahead has already committed
  assign push_data = mem_r[push_addr] & width_mask(org_r);

  // drive enable follows buffer occupancy, so nothing drives while idle
  dsb_buf #(
    .W     (DSB_DATA_W),
    .DEPTH (DSB_BUF_DEPTH)
  ) u_rd_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (push_v),
    .in_data   (push_data),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (rd_data),
    .out_ready (rd_ready)
  );

  assign rd_valid    = buf_out_valid;
  assign rd_drive_en = buf_out_valid;

  // axi4-lite write channel: address and data taken in either order
  assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= DSB_RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= '0;
      w_strb_r      <= '0;
    end else begin
      if (!aw_got_r && !s_axi_awready && !s_axi_bvalid) s_axi_awready <= 1'b1;
      if (!w_got_r && !s_axi_wready && !s_axi_bvalid) s_axi_wready <= 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got_r      <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got_r      <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r[7:2] <= DSB_OFF_REFUSED[7:2]) ? DSB_RESP_OKAY : DSB_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // changing organisation with bursts in flight mixes lane rules mid-burst
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      org_r <= DSB_ORG_RST;
    end else if (do_write && aw_addr_r[7:2] == DSB_OFF_CTRL[7:2] && w_strb_r[0]) begin
      org_r <= dsb_org_t'(w_data_r[DSB_CTRL_ORG_LSB +: 2]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= DSB_RESP_OKAY;
    end else begin
      if (!s_axi_arready && !s_axi_rvalid) s_axi_arready <= 1'b1;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= DSB_RESP_OKAY;
        s_axi_rdata   <= '0;
        unique case (s_axi_araddr[7:2])
          DSB_OFF_CTRL[7:2]:    s_axi_rdata[DSB_CTRL_ORG_LSB +: 2] <= org_r;
          DSB_OFF_STATUS[7:2]: begin
            s_axi_rdata[DSB_STAT_SCLK_BIT]   <= single_clk_r;
            s_axi_rdata[DSB_STAT_BUSY_BIT]   <= cmd_a_v_r | cmd_b_v_r | wb_v_r | rd2_v_r;
            s_axi_rdata[DSB_STAT_RDPEND_BIT] <= buf_out_valid;
            s_axi_rdata[DSB_STAT_ROOM_BIT]   <= room & buf_in_ready;
          end
          DSB_OFF_WRBEATS[7:2]: s_axi_rdata[DSB_CNT_W-1:0] <= wr_beats_r;
          DSB_OFF_REFUSED[7:2]: s_axi_rdata[DSB_CNT_W-1:0] <= refused_r;
          default:              s_axi_rresp <= DSB_RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

endmodule : dsb_core

/* File: test/dsb_core_asserts.sv */
`timescale 1ns/1ps
module dsb_core_asserts
  import dsb_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic [DSB_AXI_AW-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  load_cmd_n,
  input wire logic                  read_not_write,
  input wire logic                  k_rise_phase,
  input wire logic                  read_room,
  input wire logic [DSB_DATA_W-1:0] rd_data,
  input wire logic                  rd_valid,
  input wire logic                  rd_drive_en,
  input wire logic                  rd_ready
);
  logic rd_load_seen;
  assign rd_load_seen = !load_cmd_n && read_not_write && k_rise_phase;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_phase_toggle: assert property ($past(aresetn) |-> k_rise_phase != $past(k_rise_phase))
    else $error("phase marker stuck");
  a_read_latency: assert property (rd_load_seen && read_room |-> !rd_valid [*4] ##1 rd_valid)
    else $error("read word late or early");
  a_rise_cause: assert property ($rose(rd_valid) |-> $past(rd_load_seen, 4))
    else $error("read data without a read load");
  a_drive_match: assert property (rd_drive_en == rd_valid)
    else $error("pin enable differs from valid");
  a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("stalled read word lost");
  a_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken before response");
  a_r_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
    s_axi_rresp == ($past(s_axi_araddr) > 8'h0f ? DSB_RESP_SLVERR : DSB_RESP_OKAY))
    else $error("read response wrong");
endmodule : dsb_core_asserts

bind dsb_core dsb_core_asserts u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .load_cmd_n(load_cmd_n),
  .read_not_write(read_not_write), .k_rise_phase(k_rise_phase), .read_room(read_room),
  .rd_data(rd_data), .rd_valid(rd_valid), .rd_drive_en(rd_drive_en), .rd_ready(rd_ready)
);

/* File: test/dsb_ctl_model.sv */
`timescale 1ns/1ps
module dsb_ctl_model
  import dsb_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  k_rise_phase,
  input  wire logic [DSB_DATA_W-1:0] rd_data,
  input  wire logic                  rd_valid,
  output logic                       load_cmd_n,
  output logic                       read_not_write,
  output logic [DSB_ADDR_W-1:0]      mem_addr,
  output logic [DSB_DATA_W-1:0]      wr_data,
  output logic [3:0]                 lane_write_select_n,
  output logic [1:0]                 nibble_write_select_n,
  output logic                       rd_ready
);
  initial begin
    load_cmd_n = 1'b1;
    read_not_write = 1'b0;
    mem_addr = 4'h0;
    wr_data = 36'h0;
    lane_write_select_n = 4'hf;
    nibble_write_select_n = 2'h3;
    rd_ready = 1'b0;
  end

  // old phase low at an edge means the coming cycle is a positive half
  task automatic align;
    do @(posedge aclk); while (k_rise_phase !== 1'b0);
  endtask : align

  task automatic wr(input logic [3:0] a, input logic [35:0] d0, d1,
                    input logic [3:0] l0, l1, input logic [1:0] n0, n1);
    align();
    load_cmd_n <= 1'b0;
    read_not_write <= 1'b0;
    mem_addr <= a;
    @(posedge aclk);
    load_cmd_n <= 1'b1;
    read_not_write <= 1'b1;
    mem_addr <= ~a;
    @(posedge aclk);
    wr_data <= d0;
    lane_write_select_n <= l0;
    nibble_write_select_n <= n0;
    @(posedge aclk);
    wr_data <= d1;
    lane_write_select_n <= l1;
    nibble_write_select_n <= n1;
    @(posedge aclk);
    // released lines flip so stale data cannot pass for a beat
    wr_data <= ~d1;
    lane_write_select_n <= ~l1;
    nibble_write_select_n <= ~n1;
  endtask : wr

  task automatic rd_load(input logic [3:0] a);
    align();
    load_cmd_n <= 1'b0;
    read_not_write <= 1'b1;
    mem_addr <= a;
    @(posedge aclk);
    load_cmd_n <= 1'b1;
    read_not_write <= 1'b0;
    mem_addr <= ~a;
  endtask : rd_load

  task automatic rd_take(input int stall, output logic [35:0] q0, q1);
    int n;
    n = 0;
    q0 = 'x;
    q1 = 'x;
    for (int i = 0; i < 60 && n < 2; i++) begin
      @(posedge aclk);
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        if (n == 0) q0 = rd_data;
        else q1 = rd_data;
        n++;
      end
      rd_ready <= (i >= stall) && (n < 2);
    end
  endtask : rd_take
endmodule : dsb_ctl_model

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb import dsb_pkg::*; ();
  logic        aclk = 1'b0, aresetn = 1'b0, single_clock_strap = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, nibble_write_select_n;
  logic [31:0] s_axi_rdata;
  logic        load_cmd_n, read_not_write, k_rise_phase, read_room, rd_valid, rd_drive_en, rd_ready;
  logic [3:0]  mem_addr, lane_write_select_n;
  logic [35:0] wr_data, rd_data, q0, q1;
  logic [35:0] shm [16] = '{default: 36'h0};
  dsb_org_t    org = DSB_ORG_RST;
  int          num_errors = 0, compares = 0, beats = 0, cyc = 0;

  always #5 aclk = ~aclk;

  dsb_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .single_clock_strap, .load_cmd_n, .read_not_write, .mem_addr, .wr_data,
    .lane_write_select_n, .nibble_write_select_n, .k_rise_phase, .read_room, .rd_data,
    .rd_valid, .rd_drive_en, .rd_ready);
  dsb_ctl_model ctl (.aclk, .k_rise_phase, .rd_data, .rd_valid, .load_cmd_n, .read_not_write,
    .mem_addr, .wr_data, .lane_write_select_n, .nibble_write_select_n, .rd_ready);

  task automatic chk(input logic [35:0] g, e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // lanes written for a beat; all selects low gives the organisation width
  function automatic logic [35:0] bmask(dsb_org_t o, logic [3:0] l, logic [1:0] n);
    case (o)
      DSB_ORG_X8:  return {28'h0, {4{~n[1]}}, {4{~n[0]}}};
      DSB_ORG_X9:  return {27'h0, {9{~l[0]}}};
      DSB_ORG_X18: return {18'h0, {9{~l[1]}}, {9{~l[0]}}};
      default:     return {{9{~l[3]}}, {9{~l[2]}}, {9{~l[1]}}, {9{~l[0]}}};
    endcase
  endfunction : bmask

  function automatic logic [3:0] first(logic [3:0] a);
    return (org == DSB_ORG_X8 || org == DSB_ORG_X9) ? {a[3:1], 1'b0} : a;
  endfunction : first

  task automatic set_org(input dsb_org_t o);
    axi_wr(DSB_OFF_CTRL, {30'h0, o});
    org = o;
  endtask : set_org

  task automatic mw(input logic [3:0] a, input logic [35:0] d0, d1,
                    input logic [3:0] l0, l1, input logic [1:0] n0, n1);
    logic [35:0] m0, m1;
    logic [3:0]  a1;
    m0 = bmask(org, l0, n0);
    m1 = bmask(org, l1, n1);
    a1 = first(a);
    shm[a1] = (shm[a1] & ~m0) | (d0 & m0);
    shm[a1 ^ 4'h1] = (shm[a1 ^ 4'h1] & ~m1) | (d1 & m1);
    beats += int'(m0 != 0) + int'(m1 != 0);
    ctl.wr(a, d0, d1, l0, l1, n0, n1);
  endtask : mw

  task automatic mr(input logic [3:0] a, input int stall);
    logic [35:0] wm;
    wm = bmask(org, 4'h0, 2'h0);
    ctl.rd_load(a);
    ctl.rd_take(stall, q0, q1);
    chk(q0, shm[first(a)] & wm);
    chk(q1, shm[first(a) ^ 4'h1] & wm);
  endtask : mr

  task automatic t_regs;
    chk(36'(rd_drive_en), 36'h0);
    axi_rd(DSB_OFF_CTRL);
    chk(36'(d[1:0]), 36'(DSB_ORG_RST));
    axi_rd(DSB_OFF_STATUS);
    chk(36'(d[DSB_STAT_SCLK_BIT]), 36'h1);
    axi_rd(8'h10);
    chk(36'(r), 36'(DSB_RESP_SLVERR));
    axi_wr(8'h14, 32'h0);
    chk(36'(r), 36'(DSB_RESP_SLVERR));
    $display("t_regs done");
  endtask : t_regs

  task automatic t_wide;
    mw(4'h5, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0, 2'h3, 2'h3);
    mr(4'h5, 0);
    for (int i = 0; i < 4; i++) begin
      mw(4'h4, 36'hacacacaca, 36'h5a5a5a5a5, ~(4'h1 << i), 4'hf, 2'h3, 2'h3);
      mr(4'h4, 6);
    end
    set_org(DSB_ORG_X18);
    mw(4'h3, 36'h3ffff, 36'h0, 4'he, 4'hd, 2'h3, 2'h3);
    mr(4'h3, 2);
    mr(4'h2, 0);
    $display("t_wide done");
  endtask : t_wide

  task automatic t_narrow;
    set_org(DSB_ORG_X9);
    mw(4'h7, 36'h1a5, 36'h0f0, 4'he, 4'hf, 2'h3, 2'h3);
    mw(4'h6, 36'h111, 36'h0cc, 4'hf, 4'he, 2'h3, 2'h3);
    mr(4'h7, 0);
    set_org(DSB_ORG_X8);
    mw(4'h9, 36'h3c, 36'hc3, 4'hf, 4'hf, 2'h2, 2'h1);
    mw(4'h8, 36'hff, 36'hff, 4'h0, 4'h0, 2'h3, 2'h3);
    mr(4'h8, 3);
    $display("t_narrow done");
  endtask : t_narrow

  task automatic t_refuse;
    int n;
    set_org(DSB_ORG_X36);
    axi_rd(DSB_OFF_REFUSED);
    n = int'(d[15:0]);
    ctl.rd_load(4'h5);
    repeat (6) @(posedge aclk);
    // buffer full and stalled: this load must be dropped
    ctl.rd_load(4'ha);
    ctl.rd_take(0, q0, q1);
    chk(q0, shm[5]);
    chk(q1, shm[4]);
    repeat (8) @(posedge aclk);
    chk(36'(rd_valid), 36'h0);
    axi_rd(DSB_OFF_REFUSED);
    chk(36'(d[15:0]), 36'(n + 1));
    axi_rd(DSB_OFF_WRBEATS);
    chk(36'(d[15:0]), 36'(beats));
    $display("t_refuse done");
  endtask : t_refuse

  task automatic give_verdict;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_wide();
    t_narrow();
    t_refuse();
    give_verdict();
  end
endmodule : tb
